// *** rtl/csm_pkg.sv ***
/*
 * Shared constants for the clock stop monitor and reset cause block:
 * register offsets, field positions, reset values, detector count, states.
 * Assumes byte-wide registers on a plain strobe port with byte addresses.
 */
package csm_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] CSM_OFS_CAUSE = 8'h00;
	localparam logic [7:0] CSM_OFS_MODE  = 8'h01;

	localparam logic [7:0] CSM_CAUSE_RST = 8'h00;
	localparam logic [7:0] CSM_MODE_RST  = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned CSM_BIT_WDT    = 4;
	localparam int unsigned CSM_BIT_CLM    = 1;
	localparam int unsigned CSM_BIT_LVI    = 0;
	localparam int unsigned CSM_BIT_ENABLE = 0;

	// ----------------------------------------------------------------
	// Detector timing
	// ----------------------------------------------------------------
	// Ring oscillator sample periods without a main clock edge
	localparam int unsigned CSM_STOP_LIMIT = 4;

	// ----------------------------------------------------------------
	// Monitor states, Gray along off, wait, run
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CSM_MON_OFF  = 2'h0,
		CSM_MON_WAIT = 2'h1,
		CSM_MON_RUN  = 2'h3
	} csm_mon_e;

endpackage

// *** rtl/csm_stop_detect.sv ***
/*
 * Stopped-clock detector: counts ring oscillator sample ticks since the
 * last main oscillator level change and pulses when the limit is reached.
 * Assumes main_osc_level and ring_tick are synchronous to clock.
 */
`timescale 1ns/1ps
`default_nettype none

module csm_stop_detect #(
	parameter int unsigned LIMIT = csm_pkg::CSM_STOP_LIMIT,
	parameter int unsigned CW    = 4
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic active,
	input  wire logic ring_tick,
	input  wire logic main_osc_level,
	output logic      stopped
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (LIMIT < 2 || LIMIT >= (1 << CW)) begin : g_bad_limit
		$error("csm_stop_detect: LIMIT must be 2 or more and fit in CW bits");
	end

	localparam logic [CW-1:0] LIM_M1 = CW'(LIMIT - 1);
	localparam logic [CW-1:0] LIM    = CW'(LIMIT);

	logic          level_prev_r;
	logic [CW-1:0] cnt_r;
	logic          stopped_r;
	logic          edge_seen;

	assign edge_seen = main_osc_level ^ level_prev_r;
	assign stopped   = stopped_r;

	// ----------------------------------------------------------------
	// Edge history
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			level_prev_r <= 1'b0;
		end else begin
			level_prev_r <= main_osc_level;
		end
	end

	// ----------------------------------------------------------------
	// Tick counter, restarted by every main clock edge
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n || !active || edge_seen) begin
			cnt_r <= '0;
		end else if (ring_tick && cnt_r != LIM) begin
			cnt_r <= cnt_r + CW'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			stopped_r <= 1'b0;
		end else begin
			stopped_r <= active && !edge_seen && ring_tick && cnt_r == LIM_M1;
		end
	end

endmodule

`default_nettype wire

// *** rtl/csm_cause_flags.sv ***
/*
 * Reset cause flag byte: sticky per-source flags, cleared by the pin
 * reset, power-on clear or a read. Assumes single-cycle set pulses.
 */
`timescale 1ns/1ps
`default_nettype none

module csm_cause_flags (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       poc_clear,
	input  wire logic       rd_clear,
	input  wire logic       set_wdt,
	input  wire logic       set_clm,
	input  wire logic       set_lvi,
	output logic [7:0]      flags
);

	logic [7:0] set_vec;
	logic [7:0] flags_r;

	always_comb begin
		set_vec = 8'h00;
		set_vec[csm_pkg::CSM_BIT_WDT] = set_wdt;
		set_vec[csm_pkg::CSM_BIT_CLM] = set_clm;
		set_vec[csm_pkg::CSM_BIT_LVI] = set_lvi;
	end

	assign flags = flags_r;

	// ----------------------------------------------------------------
	// One sticky flag per bit; unused bits never set
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 8; i++) begin : g_flag
		always_ff @(posedge clock) begin
			if (!rst_n || poc_clear) begin
				flags_r[i] <= csm_pkg::CSM_CAUSE_RST[i];
			end else if (set_vec[i]) begin
				flags_r[i] <= 1'b1;
			end else if (rd_clear) begin
				flags_r[i] <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// *** rtl/csm_top.sv ***
/*
 * Clock stop monitor with reset cause register. Watches the main
 * oscillator with ring oscillator ticks and requests an internal reset
 * when it stops. Assumes all inputs are synchronous to clock, internal
 * reset requests arrive as one-cycle pulses, and the stabilization busy
 * input is high for every oscillation stabilization period.
 */
`timescale 1ns/1ps
`default_nettype none

module csm_top #(
	parameter int unsigned STOP_LIMIT = csm_pkg::CSM_STOP_LIMIT
) (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wr_data,
	input  wire logic       reg_wr_en,
	input  wire logic       reg_rd_en,
	output logic [7:0]      reg_rd_data,
	input  wire logic       poc_reset,
	input  wire logic       wdt_reset_req,
	input  wire logic       lvi_reset_req,
	input  wire logic       stop_mode,
	input  wire logic       stabilization_busy,
	input  wire logic       main_osc_stop_bit,
	input  wire logic       main_clock_cut_bit,
	input  wire logic       cpu_clk_ring,
	input  wire logic       cpu_clk_subsys,
	input  wire logic       ring_oscillator_running,
	input  wire logic       ring_oscillator_tick,
	input  wire logic       main_osc_level,
	output logic            clm_reset_req,
	output logic            monitor_active,
	output logic [1:0]      monitor_state
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic             enable_r;
	logic             enable_nxt;
	logic             clm_reset_r;
	logic             active_r;
	logic [7:0]       rd_data_r;
	logic [7:0]       cause_flags;
	logic             stop_seen;
	logic             internal_reset;
	logic             sw_main_stop;
	logic             pause;
	logic             wr_mode;
	logic             rd_cause;
	csm_pkg::csm_mon_e mon_r;
	csm_pkg::csm_mon_e mon_nxt;

	assign wr_mode  = reg_wr_en && reg_addr == csm_pkg::CSM_OFS_MODE;
	assign rd_cause = reg_rd_en && reg_addr == csm_pkg::CSM_OFS_CAUSE;

	assign internal_reset = wdt_reset_req || lvi_reset_req || clm_reset_r || poc_reset;

	assign reg_rd_data    = rd_data_r;
	assign clm_reset_req  = clm_reset_r;
	assign monitor_active = active_r;
	assign monitor_state  = mon_r;

	// ----------------------------------------------------------------
	// Monitor enable bit
	// ----------------------------------------------------------------
	always_comb begin
		enable_nxt = enable_r;
		if (internal_reset) begin
			enable_nxt = 1'b0;
		end else if (wr_mode && reg_wr_data[csm_pkg::CSM_BIT_ENABLE]) begin
			enable_nxt = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			enable_r <= csm_pkg::CSM_MODE_RST[csm_pkg::CSM_BIT_ENABLE];
		end else begin
			enable_r <= enable_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Automatic pause conditions
	// ----------------------------------------------------------------
	always_comb begin
		sw_main_stop = 1'b0;
		if (cpu_clk_ring) begin
			sw_main_stop = main_osc_stop_bit;
		end else if (cpu_clk_subsys) begin
			sw_main_stop = main_clock_cut_bit;
		end
	end

	// Stabilization busy covers reset, stop-mode and restart periods
	assign pause = stabilization_busy || stop_mode || sw_main_stop || !ring_oscillator_running;

	// ----------------------------------------------------------------
	// Monitor state
	// ----------------------------------------------------------------
	always_comb begin
		case ({enable_nxt, pause})
			2'h2:    mon_nxt = csm_pkg::CSM_MON_RUN;
			2'h3:    mon_nxt = csm_pkg::CSM_MON_WAIT;
			default: mon_nxt = csm_pkg::CSM_MON_OFF;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mon_r    <= csm_pkg::CSM_MON_OFF;
			active_r <= 1'b0;
		end else begin
			mon_r    <= mon_nxt;
			active_r <= mon_nxt == csm_pkg::CSM_MON_RUN;
		end
	end

	// ----------------------------------------------------------------
	// Stopped-clock detection and reset request
	// ----------------------------------------------------------------
	csm_stop_detect #(
		.LIMIT (STOP_LIMIT),
		.CW    ($clog2(STOP_LIMIT + 1))
	) u_detect (
		.clock          (clock),
		.rst_n          (rst_n),
		.active         (active_r),
		.ring_tick      (ring_oscillator_tick),
		.main_osc_level (main_osc_level),
		.stopped        (stop_seen)
	);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			clm_reset_r <= 1'b0;
		end else begin
			clm_reset_r <= stop_seen && active_r && !pause;
		end
	end

	// ----------------------------------------------------------------
	// Reset cause byte
	// ----------------------------------------------------------------
	csm_cause_flags u_cause (
		.clock     (clock),
		.rst_n     (rst_n),
		.poc_clear (poc_reset),
		.rd_clear  (rd_cause),
		.set_wdt   (wdt_reset_req),
		.set_clm   (clm_reset_r),
		.set_lvi   (lvi_reset_req),
		.flags     (cause_flags)
	);

	// ----------------------------------------------------------------
	// Read port, data one cycle after the strobe
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rd_data_r <= 8'h00;
		end else if (reg_rd_en) begin
			case (reg_addr)
				csm_pkg::CSM_OFS_CAUSE: rd_data_r <= cause_flags;
				csm_pkg::CSM_OFS_MODE:  rd_data_r <= {7'h00, enable_r};
				default:                rd_data_r <= 8'h00;
			endcase
		end else begin
			rd_data_r <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_stop_event;
		stop_seen && active_r && !pause;
	endsequence

	sequence s_clm_reset_done;
		clm_reset_r ##1 (!enable_r && cause_flags[csm_pkg::CSM_BIT_CLM]);
	endsequence

	property p_pin_reset_clears;
		disable iff (1'b0)
		!rst_n |=> (cause_flags == 8'h00 && !enable_r && !active_r && !clm_reset_r);
	endproperty
	a_pin_reset_clears: assert property (p_pin_reset_clears) else $error("pin reset did not clear");

	property p_read_clears;
		rd_cause && !poc_reset && !wdt_reset_req && !lvi_reset_req && !clm_reset_r
			|=> cause_flags == 8'h00 && rd_data_r == $past(cause_flags);
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("cause read did not clear");

	property p_reserved_zero;
		(cause_flags & 8'hEC) == 8'h00 && rd_data_r[7:5] == 3'h0 && rd_data_r[3:2] == 2'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved cause bit set");

	property p_wdt_only;
		wdt_reset_req && !poc_reset && !lvi_reset_req && !clm_reset_r && !rd_cause
			|=> cause_flags[csm_pkg::CSM_BIT_WDT]
			&& cause_flags[csm_pkg::CSM_BIT_LVI] == $past(cause_flags[csm_pkg::CSM_BIT_LVI])
			&& cause_flags[csm_pkg::CSM_BIT_CLM] == $past(cause_flags[csm_pkg::CSM_BIT_CLM]);
	endproperty
	a_wdt_only: assert property (p_wdt_only) else $error("watchdog flag wrong");

	property p_lvi_set_wins;
		lvi_reset_req && !poc_reset |=> cause_flags[csm_pkg::CSM_BIT_LVI];
	endproperty
	a_lvi_set_wins: assert property (p_lvi_set_wins) else $error("low voltage flag lost");

	property p_stop_resets;
		s_stop_event |=> clm_reset_r;
	endproperty
	a_stop_resets: assert property (p_stop_resets) else $error("no reset on clock stop");

	property p_clm_effect;
		clm_reset_r && !poc_reset |-> s_clm_reset_done;
	endproperty
	a_clm_effect: assert property (p_clm_effect) else $error("monitor reset effect missing");

	property p_enable_write;
		wr_mode && reg_wr_data[csm_pkg::CSM_BIT_ENABLE] && !internal_reset |=> enable_r;
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable write lost");

	property p_enable_sticky;
		enable_r && !internal_reset |=> enable_r;
	endproperty
	a_enable_sticky: assert property (p_enable_sticky) else $error("enable cleared by software");

	property p_paused;
		pause |=> (!active_r && !clm_reset_r) ##1 !clm_reset_r;
	endproperty
	a_paused: assert property (p_paused) else $error("monitor ran while paused");

	property p_resume;
		enable_r && !internal_reset && !pause ##0 $past(pause) |=> active_r;
	endproperty
	a_resume: assert property (p_resume) else $error("monitor did not resume");

	property p_subsys_cut;
		cpu_clk_subsys && !cpu_clk_ring && main_clock_cut_bit |=> !active_r;
	endproperty
	a_subsys_cut: assert property (p_subsys_cut) else $error("clock cut bit ignored");

	property p_read_idle_zero;
		!reg_rd_en |=> rd_data_r == 8'h00;
	endproperty
	a_read_idle_zero: assert property (p_read_idle_zero) else $error("read data not idle");

	property p_unmapped_zero;
		reg_rd_en && reg_addr != csm_pkg::CSM_OFS_CAUSE && reg_addr != csm_pkg::CSM_OFS_MODE
			|=> rd_data_r == 8'h00;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

	property p_no_req_disabled;
		!enable_r |=> !clm_reset_r;
	endproperty
	a_no_req_disabled: assert property (p_no_req_disabled) else $error("reset while disabled");

	property p_active_needs_enable;
		active_r |-> enable_r;
	endproperty
	a_active_needs_enable: assert property (p_active_needs_enable) else $error("active without enable");

	property p_clm_pulse;
		clm_reset_r |=> !clm_reset_r;
	endproperty
	a_clm_pulse: assert property (p_clm_pulse) else $error("monitor reset longer than one cycle");

	property p_wait_state;
		enable_r && pause && !internal_reset |=> mon_r == csm_pkg::CSM_MON_WAIT;
	endproperty
	a_wait_state: assert property (p_wait_state) else $error("paused monitor not waiting");

endmodule

`default_nettype wire

// *** verif/csm_osc_model.sv ***
/*
 * Far-side model: main oscillator level and ring oscillator sample ticks.
 * Assumes run and ring_run change just after rising clock edges.
 */
`timescale 1ns/1ps
`default_nettype none

module csm_osc_model (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic run,
	input  wire logic ring_run,
	output logic      main_level,
	output logic      ring_tick
);
	logic [1:0] phase_r;

	// Level change and tick never share a cycle; a stopped clock holds
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			phase_r    <= 2'h0;
			main_level <= 1'b0;
			ring_tick  <= 1'b0;
		end else begin
			phase_r   <= phase_r + 2'h1;
			ring_tick <= ring_run && (phase_r == 2'h2);
			if (run && (phase_r == 2'h0)) begin
				main_level <= !main_level;
			end
		end
	end
endmodule

`default_nettype wire

// *** verif/csm_top_bench.sv ***
/*
 * Self-checking bench for csm_top: register tasks, pause conditions,
 * stop detection, cause flags. Assumes the oscillator model beside it.
 */
`timescale 1ns/1ps
`default_nettype none

module csm_top_bench;
	localparam int unsigned STOP_LIMIT = 3;

	logic       clock;
	logic       rst_n;
	logic [7:0] reg_addr;
	logic [7:0] reg_wr_data;
	logic       reg_wr_en;
	logic       reg_rd_en;
	logic [7:0] reg_rd_data;
	logic       poc_reset;
	logic       wdt_reset_req;
	logic       lvi_reset_req;
	logic       stop_mode;
	logic       stabilization_busy;
	logic       main_osc_stop_bit;
	logic       main_clock_cut_bit;
	logic       cpu_clk_ring;
	logic       cpu_clk_subsys;
	logic       ring_run;
	logic       osc_run;
	logic       ring_oscillator_tick;
	logic       main_osc_level;
	logic       clm_reset_req;
	logic       monitor_active;
	logic [1:0] monitor_state;
	logic [7:0] req_count;
	logic [7:0] ticks;
	int         mismatches;
	int         num_checks;
	int         n;

	csm_top #(.STOP_LIMIT(STOP_LIMIT)) u_csm_top (
		.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
		.poc_reset(poc_reset), .wdt_reset_req(wdt_reset_req),
		.lvi_reset_req(lvi_reset_req), .stop_mode(stop_mode),
		.stabilization_busy(stabilization_busy), .main_osc_stop_bit(main_osc_stop_bit),
		.main_clock_cut_bit(main_clock_cut_bit), .cpu_clk_ring(cpu_clk_ring),
		.cpu_clk_subsys(cpu_clk_subsys), .ring_oscillator_running(ring_run),
		.ring_oscillator_tick(ring_oscillator_tick), .main_osc_level(main_osc_level),
		.clm_reset_req(clm_reset_req), .monitor_active(monitor_active),
		.monitor_state(monitor_state)
	);

	csm_osc_model u_csm_osc_model (
		.clock(clock), .rst_n(rst_n), .run(osc_run), .ring_run(ring_run),
		.main_level(main_osc_level), .ring_tick(ring_oscillator_tick)
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			req_count <= 8'h00;
		end else if (clm_reset_req === 1'b1) begin
			req_count <= req_count + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic timeout();
		mismatches++;
		$display("CHECK FAILED wait expected done seen timeout");
		close_out();
	endtask

	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic step();
		@(posedge clock);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr    <= a;
		reg_wr_data <= d;
		reg_wr_en   <= 1'b1;
		step();
		reg_wr_en   <= 1'b0;
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
		reg_addr  <= a;
		reg_rd_en <= 1'b1;
		step();
		reg_rd_en <= 1'b0;
		chk_byte(what, exp, reg_rd_data);
		step();
	endtask

	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (6) step();
		rst_n <= 1'b1;
	endtask

	// Pause conditions 0..4; 5 and 6 are stop bits that must not count
	task automatic apply(input int k, input logic v);
		case (k)
			0: stop_mode <= v;
			1: begin
				cpu_clk_ring      <= v;
				main_osc_stop_bit <= v;
			end
			2: begin
				cpu_clk_subsys     <= v;
				main_clock_cut_bit <= v;
			end
			3: ring_run <= !v;
			4: stabilization_busy <= v;
			5: begin
				cpu_clk_ring       <= v;
				main_clock_cut_bit <= v;
			end
			default: begin
				main_osc_stop_bit  <= v;
				main_clock_cut_bit <= v;
			end
		endcase
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{reg_addr, reg_wr_data, reg_wr_en, reg_rd_en} = 18'h0_0000;
		{poc_reset, wdt_reset_req, lvi_reset_req, stop_mode} = 4'h0;
		{main_osc_stop_bit, main_clock_cut_bit, cpu_clk_ring, cpu_clk_subsys} = 4'h0;
		stabilization_busy = 1'b1;
		ring_run = 1'b1;
		osc_run = 1'b1;
		rst_n = 1'b0;
		mismatches = 0;
		num_checks = 0;
		do_reset();
		rd_chk("cause reset", csm_pkg::CSM_OFS_CAUSE, 8'h00);
		rd_chk("mode reset", csm_pkg::CSM_OFS_MODE, 8'h00);
		rd_chk("unmapped", 8'h05, 8'h00);
		wr(csm_pkg::CSM_OFS_MODE, 8'h01);
		chk_byte("state busy", 8'h01, {6'h00, monitor_state});
		repeat (10) step();
		chk_bit("active busy", 1'b0, monitor_active);
		stabilization_busy <= 1'b0;
		step();
		chk_bit("active start", 1'b1, monitor_active);
		wr(csm_pkg::CSM_OFS_MODE, 8'h00);
		rd_chk("mode after 0", csm_pkg::CSM_OFS_MODE, 8'h01);
		for (int k = 0; k < 7; k++) begin
			apply(k, 1'b1);
			step();
			chk_bit("active cond", 1'(k > 4), monitor_active);
			if (k < 5) begin
				chk_byte("state cond", 8'h01, {6'h00, monitor_state});
				osc_run <= 1'b0;
				repeat (30) step();
				chk_byte("req paused", 8'h00, req_count);
				osc_run <= 1'b1;
			end
			apply(k, 1'b0);
			step();
			chk_bit("active resume", 1'b1, monitor_active);
		end
		n = 0;
		while (ring_oscillator_tick !== 1'b1 && n < 20) begin
			step();
			n++;
		end
		if (n >= 20) begin
			timeout();
		end
		osc_run <= 1'b0;
		ticks = 8'h00;
		n = 0;
		while (clm_reset_req !== 1'b1 && n < 100) begin
			step();
			n++;
			if (ring_oscillator_tick === 1'b1) begin
				ticks++;
			end
		end
		if (n >= 100) begin
			timeout();
		end
		chk_byte("stop ticks", 8'(STOP_LIMIT - 1), ticks);
		osc_run <= 1'b1;
		step();
		chk_bit("active after req", 1'b0, monitor_active);
		chk_bit("req pulse", 1'b0, clm_reset_req);
		chk_byte("req count", 8'h01, req_count);
		chk_byte("state after req", 8'h00, {6'h00, monitor_state});
		rd_chk("mode after req", csm_pkg::CSM_OFS_MODE, 8'h00);
		rd_chk("cause clm", csm_pkg::CSM_OFS_CAUSE, 8'h02);
		rd_chk("cause cleared", csm_pkg::CSM_OFS_CAUSE, 8'h00);
		stabilization_busy <= 1'b1;
		step();
		stabilization_busy <= 1'b0;
		wr(csm_pkg::CSM_OFS_MODE, 8'h01);
		chk_bit("active at end", 1'b1, monitor_active);
		wdt_reset_req <= 1'b1;
		step();
		wdt_reset_req <= 1'b0;
		step();
		rd_chk("mode after wdt", csm_pkg::CSM_OFS_MODE, 8'h00);
		lvi_reset_req <= 1'b1;
		step();
		lvi_reset_req <= 1'b0;
		step();
		rd_chk("cause wdt lvi", csm_pkg::CSM_OFS_CAUSE, 8'h11);
		rd_chk("cause read clr", csm_pkg::CSM_OFS_CAUSE, 8'h00);
		wdt_reset_req <= 1'b1;
		step();
		wdt_reset_req <= 1'b0;
		poc_reset <= 1'b1;
		step();
		poc_reset <= 1'b0;
		step();
		rd_chk("cause poc", csm_pkg::CSM_OFS_CAUSE, 8'h00);
		wr(csm_pkg::CSM_OFS_MODE, 8'hff);
		step();
		rd_chk("mode byte", csm_pkg::CSM_OFS_MODE, 8'h01);
		do_reset();
		chk_bit("active pin rst", 1'b0, monitor_active);
		rd_chk("mode pin rst", csm_pkg::CSM_OFS_MODE, 8'h00);
		close_out();
	end

	initial begin
		#1000000;
		timeout();
	end
endmodule

`default_nettype wire
